// *** design/seg_io_pkg.sv ***
`default_nettype none
package seg_io_pkg;

  // ----------------------------------------------------------------
  // Segment allocation
  // ----------------------------------------------------------------
  localparam int unsigned SEG_COUNT_W   = 5;
  localparam int unsigned SEG_COUNT_MAX = 18;
  localparam int unsigned SHARED_W      = 12;   // Seg 24..31 and 34..37
  localparam int unsigned DIO_W         = 18;   // Dio 0..17, index = number
  localparam int unsigned FIRST_SEG_SET = 5;    // First setting taking a pin
  localparam int unsigned HIGH_GRP_LAST = 8;    // Setting that fills seg 34..37
  localparam int unsigned LOW_GRP_FIRST = 11;   // First setting for seg 31..24
  localparam int unsigned HIGH_GRP_N    = 4;
  localparam int unsigned LOW_GRP_N     = 8;
  localparam int unsigned SEG_DIO_OFS   = 20;   // Dio number = seg - 20
  localparam int unsigned SEG_LOW_BASE  = 24;   // Segment on shared bit 0
  localparam int unsigned SEG_HIGH_BASE = 34;   // Segment on shared bit 8
  localparam int unsigned DIO_EE_CLK    = 4;
  localparam int unsigned DIO_EE_DAT    = 5;
  localparam int unsigned DIO_OPT_A     = 1;
  localparam int unsigned DIO_OPT_B     = 2;

  typedef enum logic [1:0] {
    EE_NONE  = 2'h0,
    EE_2WIRE = 2'h1,
    EE_3WIRE = 2'h2,
    EE_RSVD  = 2'h3
  } ee_mode_t;

  // ----------------------------------------------------------------
  // Optical carrier
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ       = 10_000_000;
  localparam int unsigned CARRIER_HZ   = 38_000;
  localparam int unsigned CARRIER_CYC  = CLK_HZ / CARRIER_HZ;  // Rounds down
  localparam int unsigned CAR_W        = 9;
  localparam int unsigned DUTY_SHIFT_0 = 1;   // 50%
  localparam int unsigned DUTY_SHIFT_1 = 2;   // 25%
  localparam int unsigned DUTY_SHIFT_2 = 3;   // 12.5%
  localparam int unsigned DUTY_SHIFT_3 = 4;   // 6.25%

  typedef struct packed {
    logic       tx_disable;
    logic       tx_invert;
    logic       rx_invert;
    logic       modulate_en;
    logic [1:0] duty_select;
  } optical_ctrl_t;

endpackage : seg_io_pkg
`default_nettype wire

// *** design/segment_io_and_optical_port_mux.sv ***
// Behaviour
// - Segment count setting 0..18 decides LCD versus digital use of shared pins.
// - LCD allocation starts at segment 37 and proceeds downward.
// - Setting 5 gives segment 37 only; segments 36..34 and 31..24 stay digital I/O.
// - Unallocated shared segment n acts as digital I/O number n minus 20.
// - 0-4 none, 5-8 add 37..34, 9-10 as 8, 11-18 add 31..24.
// - Digital I/O 1 and 2 never go to LCD; optical port may claim.
// - Select 01 turns I/O 4 and 5 into two-wire clock and data.
// - Select 10 turns I/O 4 and 5 into three-wire EEPROM pins.
// - Three-wire mode uses I/O 5 as shared data in and out.
// - Optical transmit pin is driven only while transmit disable is 0.
// - Transmit and receive polarity inverts independently by their own bits.
// - Modulation enable with system power gives a 38 kHz carrier.
// - No carrier modulation during brownout, whatever the enable says.
// - Duty select picks 50, 25, 12.5 or 6.25 percent.
// - Duty fraction is the low time of each carrier period.
`timescale 1ns/1ps
`default_nettype none
module segment_io_and_optical_port_mux (
  input  wire logic                                clk,
  input  wire logic                                srst,
  input  wire logic [seg_io_pkg::SEG_COUNT_W-1:0]  lcd_segment_count,
  input  wire logic [1:0]                          eeprom_port_select,
  input  wire seg_io_pkg::optical_ctrl_t           optical_ctrl,
  input  wire logic                                optical_port_uses_dio,
  input  wire logic                                system_power_ok,
  input  wire logic                                optical_tx_data,
  output logic                                     optical_rx_data,
  input  wire logic                                optical_rx_pin,
  output logic                                     optical_tx_pin,
  output logic                                     optical_tx_pin_oe_n,
  output logic [seg_io_pkg::SHARED_W-1:0]          shared_is_lcd,
  output logic [seg_io_pkg::DIO_W-1:0]             dio_is_general,
  output logic                                     ee_2wire_active,
  output logic                                     ee_3wire_active,
  output logic                                     dedicated_seg_fixed
);

  // ----------------------------------------------------------------
  // Allocation functions
  // ----------------------------------------------------------------
  // Bit i of the mask: 0..7 are seg 24..31, 8..11 are seg 34..37
  function automatic logic [seg_io_pkg::SHARED_W-1:0] lcd_mask(
      input logic [seg_io_pkg::SEG_COUNT_W-1:0] n);
    logic [seg_io_pkg::SHARED_W-1:0] m;
    int unsigned hi;
    int unsigned lo;
    m  = '0;
    hi = 0;
    lo = 0;
    // Setting 5 takes seg 37 only
    if (n >= seg_io_pkg::FIRST_SEG_SET) begin
      hi = int'(n) - seg_io_pkg::FIRST_SEG_SET + 1;
    end
    if (hi > seg_io_pkg::HIGH_GRP_N) begin
      hi = seg_io_pkg::HIGH_GRP_N;
    end
    if (n >= seg_io_pkg::LOW_GRP_FIRST) begin
      lo = int'(n) - seg_io_pkg::LOW_GRP_FIRST + 1;
    end
    if (n > seg_io_pkg::SEG_COUNT_MAX) begin
      lo = seg_io_pkg::LOW_GRP_N;
    end
    for (int i = 0; i < seg_io_pkg::HIGH_GRP_N; i++) begin
      if (i < hi) begin
        m[seg_io_pkg::SHARED_W-1-i] = 1'b1;
      end
    end
    for (int i = 0; i < seg_io_pkg::LOW_GRP_N; i++) begin
      if (i < lo) begin
        m[seg_io_pkg::LOW_GRP_N-1-i] = 1'b1;
      end
    end
    return m;
  endfunction : lcd_mask

  // Shared index to segment number
  function automatic int unsigned seg_num(input int unsigned idx);
    int unsigned s;
    s = (idx < seg_io_pkg::LOW_GRP_N) ? seg_io_pkg::SEG_LOW_BASE + idx
      : seg_io_pkg::SEG_HIGH_BASE + idx - seg_io_pkg::LOW_GRP_N;
    return s;
  endfunction : seg_num

  // ----------------------------------------------------------------
  // Pin allocation
  // ----------------------------------------------------------------
  logic [seg_io_pkg::SHARED_W-1:0] shared_d;
  logic [seg_io_pkg::SHARED_W-1:0] shared_q;
  logic [seg_io_pkg::DIO_W-1:0]    dio_d;
  logic [seg_io_pkg::DIO_W-1:0]    dio_q;
  logic                            ee2_d;
  logic                            ee2_q;
  logic                            ee3_d;
  logic                            ee3_q;

  always_comb begin
    shared_d = lcd_mask(lcd_segment_count);
    dio_d    = '0;
    for (int i = 0; i < seg_io_pkg::SHARED_W; i++) begin
      dio_d[seg_num(i) - seg_io_pkg::SEG_DIO_OFS] = ~shared_d[i];
    end
    dio_d[seg_io_pkg::DIO_OPT_A] = ~optical_port_uses_dio;
    dio_d[seg_io_pkg::DIO_OPT_B] = ~optical_port_uses_dio;
    ee2_d = (eeprom_port_select == seg_io_pkg::EE_2WIRE);
    ee3_d = (eeprom_port_select == seg_io_pkg::EE_3WIRE);
    if (ee2_d || ee3_d) begin
      dio_d[seg_io_pkg::DIO_EE_CLK] = 1'b0;
      dio_d[seg_io_pkg::DIO_EE_DAT] = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      shared_q <= '0;
      dio_q    <= '0;
      ee2_q    <= 1'b0;
      ee3_q    <= 1'b0;
    end else begin
      shared_q <= shared_d;
      dio_q    <= dio_d;
      ee2_q    <= ee2_d;
      ee3_q    <= ee3_d;
    end
  end

  // ----------------------------------------------------------------
  // Optical receive
  // ----------------------------------------------------------------
  // Pin is asynchronous; act once stages two and three agree
  logic [2:0] rx_sync_q;
  logic [2:0] rx_sync_d;
  logic       rx_q;
  logic       rx_d;

  always_comb begin
    rx_sync_d = {rx_sync_q[1:0], optical_rx_pin};
    rx_d      = rx_q;
    if (rx_sync_q[2] == rx_sync_q[1]) begin
      rx_d = rx_sync_q[2] ^ optical_ctrl.rx_invert;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rx_sync_q <= '0;
      rx_q      <= 1'b0;
    end else begin
      rx_sync_q <= rx_sync_d;
      rx_q      <= rx_d;
    end
  end

  // ----------------------------------------------------------------
  // Optical transmit
  // ----------------------------------------------------------------
  logic [seg_io_pkg::CAR_W-1:0] car_q;
  logic [seg_io_pkg::CAR_W-1:0] car_d;
  logic [seg_io_pkg::CAR_W-1:0] low_cyc;
  logic                         mod_on;
  logic                         tx_d;
  logic                         tx_q;
  logic                         oe_n_d;
  logic                         oe_n_q;

  always_comb begin
    case (optical_ctrl.duty_select)
      2'h0:    low_cyc = seg_io_pkg::CAR_W'(seg_io_pkg::CARRIER_CYC >> seg_io_pkg::DUTY_SHIFT_0);
      2'h1:    low_cyc = seg_io_pkg::CAR_W'(seg_io_pkg::CARRIER_CYC >> seg_io_pkg::DUTY_SHIFT_1);
      2'h2:    low_cyc = seg_io_pkg::CAR_W'(seg_io_pkg::CARRIER_CYC >> seg_io_pkg::DUTY_SHIFT_2);
      default: low_cyc = seg_io_pkg::CAR_W'(seg_io_pkg::CARRIER_CYC >> seg_io_pkg::DUTY_SHIFT_3);
    endcase
    car_d = (car_q == seg_io_pkg::CAR_W'(seg_io_pkg::CARRIER_CYC - 1)) ? '0
                                                                       : car_q + 1'b1;
    mod_on = optical_ctrl.modulate_en && system_power_ok;
    tx_d = optical_tx_data ^ optical_ctrl.tx_invert;
    // Low for duty part of period
    if (mod_on && car_q < low_cyc) begin
      tx_d = 1'b0;
    end
    oe_n_d = optical_ctrl.tx_disable;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      car_q  <= '0;
      tx_q   <= 1'b1;
      oe_n_q <= 1'b1;
    end else begin
      car_q  <= car_d;
      tx_q   <= tx_d;
      oe_n_q <= oe_n_d;
    end
  end

  always_ff @(posedge clk) begin
    dedicated_seg_fixed <= 1'b1;
  end

  assign shared_is_lcd       = shared_q;
  assign dio_is_general      = dio_q;
  assign ee_2wire_active     = ee2_q;
  assign ee_3wire_active     = ee3_q;
  assign optical_rx_data     = rx_q;
  assign optical_tx_pin      = tx_q;
  assign optical_tx_pin_oe_n = oe_n_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_alloc_five;
    @(posedge clk) disable iff (srst)
      lcd_segment_count == 5'h05 |=> shared_is_lcd == 12'h800;
  endproperty
  a_alloc_five: assert property (p_alloc_five) else $error("Setting 5 allocation wrong");

  property p_alloc_ten;
    @(posedge clk) disable iff (srst)
      lcd_segment_count == 5'h0a |=> shared_is_lcd == 12'hf00;
  endproperty
  a_alloc_ten: assert property (p_alloc_ten) else $error("Setting 10 allocation wrong");

  property p_alloc_full;
    @(posedge clk) disable iff (srst)
      lcd_segment_count == 5'h12 |=> shared_is_lcd == 12'hfff && dio_is_general[17:4] == '0;
  endproperty
  a_alloc_full: assert property (p_alloc_full) else $error("Setting 18 allocation wrong");

  property p_dio_seg;
    @(posedge clk) disable iff (srst)
      ##1 (!ee_2wire_active && !ee_3wire_active) |->
        dio_is_general[17] == !shared_is_lcd[11] && dio_is_general[11] == !shared_is_lcd[7];
  endproperty
  a_dio_seg: assert property (p_dio_seg) else $error("Dio and seg disagree");

  property p_ee_two;
    @(posedge clk) disable iff (srst)
      eeprom_port_select == 2'h1 |=> ee_2wire_active && !dio_is_general[4] && !dio_is_general[5];
  endproperty
  a_ee_two: assert property (p_ee_two) else $error("Two-wire not taken");

  property p_ee_three;
    @(posedge clk) disable iff (srst)
      eeprom_port_select == 2'h2 |=> ee_3wire_active && !ee_2wire_active;
  endproperty
  a_ee_three: assert property (p_ee_three) else $error("Three-wire not taken");

  property p_tx_oe;
    @(posedge clk) disable iff (srst)
      optical_ctrl.tx_disable |=> optical_tx_pin_oe_n;
  endproperty
  a_tx_oe: assert property (p_tx_oe) else $error("Tx driven while disabled");

  property p_brownout;
    @(posedge clk) disable iff (srst)
      !system_power_ok |=>
        optical_tx_pin == ($past(optical_tx_data) ^ $past(optical_ctrl.tx_invert));
  endproperty
  a_brownout: assert property (p_brownout) else $error("Modulated in brownout");

  property p_duty_low;
    @(posedge clk) disable iff (srst)
      (optical_ctrl.modulate_en && system_power_ok && car_q == '0) |=> !optical_tx_pin;
  endproperty
  a_duty_low: assert property (p_duty_low) else $error("Carrier not low at start");

  property p_opt_claim;
    @(posedge clk) disable iff (srst)
      !optical_port_uses_dio |=> dio_is_general[1] && dio_is_general[2];
  endproperty
  a_opt_claim: assert property (p_opt_claim) else $error("Optical pins not general");

  property p_carrier_wrap;
    @(posedge clk) disable iff (srst)
      car_q == 9'h106 |=> car_q == 9'h000;
  endproperty
  a_carrier_wrap: assert property (p_carrier_wrap) else $error("Carrier period wrong");

  property p_duty_half;
    @(posedge clk) disable iff (srst)
      (optical_ctrl.modulate_en && system_power_ok && optical_ctrl.duty_select == 2'h0 &&
       optical_tx_data && !optical_ctrl.tx_invert && car_q == 9'h083) |=> optical_tx_pin;
  endproperty
  a_duty_half: assert property (p_duty_half) else $error("Half duty low too long");

  property p_duty_sixteenth;
    @(posedge clk) disable iff (srst)
      (optical_ctrl.modulate_en && system_power_ok && optical_ctrl.duty_select == 2'h3 &&
       optical_tx_data && !optical_ctrl.tx_invert && car_q == 9'h010) |=> optical_tx_pin;
  endproperty
  a_duty_sixteenth: assert property (p_duty_sixteenth) else $error("Short duty too long");

  property p_rx_follow;
    @(posedge clk) disable iff (srst)
      (rx_sync_q[2] && rx_sync_q[1] && !optical_ctrl.rx_invert) |=> optical_rx_data;
  endproperty
  a_rx_follow: assert property (p_rx_follow) else $error("Receive level lost");

endmodule : segment_io_and_optical_port_mux
`default_nettype wire

// *** tb/test_segment_io_and_optical_port_mux.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_segment_io_and_optical_port_mux;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic                                       clk;
  logic                                       srst;
  logic [seg_io_pkg::SEG_COUNT_W-1:0]         cnt;
  logic [1:0]                                 ee_sel;
  seg_io_pkg::optical_ctrl_t                  ctrl;
  logic                                       opt_dio;
  logic                                       pwr_ok;
  logic                                       tx_data;
  logic                                       rx_pin;
  logic                                       rx_data;
  logic                                       tx_pin;
  logic                                       tx_oe_n;
  logic [seg_io_pkg::SHARED_W-1:0]            lcd_mask;
  logic [seg_io_pkg::DIO_W-1:0]               dio_mask;
  logic                                       ee2;
  logic                                       ee3;
  logic                                       ded_fixed;
  int                                         num_errors;
  int                                         n_tests;

  segment_io_and_optical_port_mux dut_u (
    .clk                   (clk),
    .srst                  (srst),
    .lcd_segment_count     (cnt),
    .eeprom_port_select    (ee_sel),
    .optical_ctrl          (ctrl),
    .optical_port_uses_dio (opt_dio),
    .system_power_ok       (pwr_ok),
    .optical_tx_data       (tx_data),
    .optical_rx_data       (rx_data),
    .optical_rx_pin        (rx_pin),
    .optical_tx_pin        (tx_pin),
    .optical_tx_pin_oe_n   (tx_oe_n),
    .shared_is_lcd         (lcd_mask),
    .dio_is_general        (dio_mask),
    .ee_2wire_active       (ee2),
    .ee_3wire_active       (ee3),
    .dedicated_seg_fixed   (ded_fixed)
  );

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic end_sim();
    $display("tests=%0d errors=%0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask : step

  // Pins fill from seg 37 downward, skipping the gap at 32/33
  function automatic logic [11:0] exp_lcd(input logic [4:0] n);
    int          nn;
    logic [11:0] m;
    nn = int'(n);
    m = 12'h000;
    for (int k = 0; k < 4; k++) if (nn >= 5 + k) m[11-k] = 1'b1;
    for (int k = 0; k < 8; k++) if (nn >= 11 + k) m[7-k] = 1'b1;
    return m;
  endfunction : exp_lcd

  function automatic logic [17:0] exp_dio(input logic [4:0] n, input logic [1:0] s,
                                          input logic o);
    logic [11:0] l;
    logic [17:0] d;
    l = exp_lcd(n);
    d = 18'h00000;
    d[1] = ~o;
    d[2] = ~o;
    d[11:4] = ~l[7:0];
    d[17:14] = ~l[11:8];
    if (s == 2'h1 || s == 2'h2) d[5:4] = 2'h0;
    return d;
  endfunction : exp_dio

  task automatic alloc(input logic [4:0] n, input logic [1:0] s, input logic o);
    cnt = n;
    ee_sel = s;
    opt_dio = o;
    step(2);
    check(32'(lcd_mask), 32'(exp_lcd(n)));
    check(32'(dio_mask), 32'(exp_dio(n, s, o)));
    check(32'(ee2), 32'(s == 2'h1));
    check(32'(ee3), 32'(s == 2'h2));
    check(32'(ded_fixed), 32'h1);
  endtask : alloc

  task automatic optic(input logic [4:0] v);
    ctrl.modulate_en = 1'b0;
    ctrl.tx_invert = v[0];
    ctrl.rx_invert = v[1];
    ctrl.tx_disable = v[2];
    tx_data = v[3];
    rx_pin = v[4];
    step(6);
    check(32'(tx_oe_n), 32'(v[2]));
    if (!v[2]) check(32'(tx_pin), 32'(v[3] ^ v[0]));
    check(32'(rx_data), 32'(v[4] ^ v[1]));
  endtask : optic

  // Counting lows over one full period is phase independent
  task automatic carrier(input logic [1:0] d, input logic p);
    int                        lows;
    int                        expv;
    seg_io_pkg::optical_ctrl_t c;
    lows = 0;
    c = '0;
    c.modulate_en = 1'b1;
    c.duty_select = d;
    ctrl = c;
    tx_data = 1'b1;
    pwr_ok = p;
    step(3);
    repeat (int'(seg_io_pkg::CARRIER_CYC)) begin
      step(1);
      if (tx_pin === 1'b0) lows++;
    end
    expv = p ? int'(seg_io_pkg::CARRIER_CYC >> (d + 1)) : 0;
    check(32'(lows), 32'(expv));
  endtask : carrier

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    num_errors = 0;
    n_tests = 0;
    srst = 1'b1;
    cnt = 5'h00;
    ee_sel = 2'h0;
    ctrl = '0;
    opt_dio = 1'b0;
    pwr_ok = 1'b1;
    tx_data = 1'b1;
    rx_pin = 1'b0;
    void'($urandom(32'ha7674b47));
    step(2);
    check(32'({lcd_mask, ee2, ee3, rx_data}), 32'h0);
    check(32'(dio_mask), 32'h0);
    check(32'({tx_pin, tx_oe_n}), 32'h3);
    srst = 1'b0;
    for (int i = 0; i < 19; i++) alloc(5'(i), 2'(i % 4), 1'(i % 2));
    for (int i = 0; i < 40; i++) begin
      alloc(5'($urandom_range(18)), 2'($urandom), 1'($urandom));
    end
    for (int i = 0; i < 32; i++) optic(5'(i));
    for (int i = 0; i < 20; i++) optic(5'($urandom));
    for (int i = 0; i < 4; i++) carrier(2'(i), 1'b1);
    carrier(2'h3, 1'b0);
    // Mid-run reset with settings that would otherwise show
    cnt = 5'h12;
    rx_pin = 1'b1;
    srst = 1'b1;
    step(2);
    check(32'(lcd_mask), 32'h0);
    check(32'({dio_mask, ee2, ee3, rx_data}), 32'h0);
    check(32'({tx_pin, tx_oe_n}), 32'h3);
    srst = 1'b0;
    alloc(5'h12, 2'h2, 1'b1);
    optic(5'h10);
    end_sim();
  end

  // Hang guard
  initial begin
    repeat (100000) @(posedge clk);
    num_errors++;
    end_sim();
  end
endmodule : test_segment_io_and_optical_port_mux
`default_nettype wire
